// file: rtl/pcstk_cfg.svh
// Purpose: constants for the program flow and indirect addressing block
// Assumes: one core clock, synchronous active-high reset
// Notes:   offsets, field positions, reset values and sizes live here
`ifndef PCSTK_CFG_SVH
`define PCSTK_CFG_SVH
`define PC_WIDTH        13
`define PC_RESET        13'h0000
`define LATCH_WIDTH     5
`define LATCH_RESET     5'h00
`define LATCH_LOAD_HI   4
`define LATCH_PAGE_BIT  3
`define BRANCH_BITS     11
`define STACK_DEPTH     8
`define PTR_RESET       8'h00
`define IND_PORT_ADDR   8'h00
`endif

// file: rtl/pcstk_pkg.sv
// Purpose: types for the program flow block
// Assumes: nothing
// Notes:   one flow command per cycle
`default_nettype none
package pcstk_pkg;
    // Program counter source selection
    typedef enum logic [2:0]
    {
        FLOW_NEXT,
        FLOW_HOLD,
        FLOW_LOW_WRITE,
        FLOW_BRANCH,
        FLOW_CALL,
        FLOW_INTERRUPT,
        FLOW_RETURN
    } flow_t;
endpackage : pcstk_pkg
`default_nettype wire

// file: rtl/pcstk.sv
// Purpose: program counter, return stack and indirect data port
// Assumes: the execute core issues one flow command per cycle
// Notes:   no software-visible stack pointer, stack wraps silently
`include "pcstk_cfg.svh"
`default_nettype none
module pcstk
    import pcstk_pkg::*;
#(
    parameter int DEPTH   = `STACK_DEPTH,   // Return stack entries
    parameter int VECTOR  = 4               // Interrupt vector address
)
(
    input  wire logic        CLK,            // Core clock
    input  wire logic        RST,            // Synchronous reset
    input  wire flow_t       FLOW,           // Flow command this cycle
    input  wire logic [10:0] TARGET,         // Opcode target for call/goto
    input  wire logic [7:0]  LOW_DATA,       // Data for low byte write
    input  wire logic        LATCH_WE,       // Write the high latch
    input  wire logic [4:0]  LATCH_DATA,     // New high latch value
    input  wire logic        PTR_WE,         // Write the pointer
    input  wire logic [7:0]  PTR_DATA,       // New pointer value
    input  wire logic        BANK_BIT,       // Status bank bit, top bit of the indirect address
    input  wire logic        IND_RE,         // Core reads indirect port
    input  wire logic        IND_WE,         // Core writes indirect port
    input  wire logic [7:0]  IND_WDATA,      // Data for indirect write
    input  wire logic [7:0]  FILE_RDATA,     // Data returned by register file
    output logic [12:0]      PC,             // Program counter
    output logic [7:0]       PC_LOW,         // Readable low byte
    output logic [4:0]       LATCH,          // High latch contents
    output logic [7:0]       POINTER,        // Pointer contents
    output logic [8:0]       FILE_ADDR,      // Indirect effective address
    output logic             FILE_RE,        // Register file read strobe
    output logic             FILE_WE,        // Register file write strobe
    output logic [7:0]       FILE_WDATA,     // Register file write data
    output logic [7:0]       IND_RDATA       // Indirect read result
);
    // Width of the stack pointer
    localparam int SPW = $clog2(DEPTH);

    // Refuse unusable depths at elaboration, the pointer wraps by width alone
    if (DEPTH < 2 || (1 << SPW) != DEPTH)
    begin : g_bad_depth
        $error("DEPTH must be a power of two of at least two");
    end

    // Refuse a vector that does not fit the counter
    if (VECTOR < 0 || VECTOR >= (1 << `PC_WIDTH))
    begin : g_bad_vector
        $error("VECTOR must fit the program counter");
    end

    logic [12:0]    pc;                     // Counter
    logic [12:0]    next_pc;                // Counter next value
    logic [4:0]     pc_high_latch;          // Upper holding latch
    logic [7:0]     file_select_pointer;    // Indirect pointer
    logic [12:0]    stack [DEPTH];          // Return stack storage
    logic [SPW-1:0] sp;                     // Hidden stack pointer
    logic [SPW-1:0] top;                    // Most recent entry
    logic           is_push;                // Push this cycle
    logic           is_pop;                 // Pop this cycle
    logic           ptr_zero;               // Pointer aims at the port

    assign top      = sp - SPW'(1);
    assign is_push  = (FLOW == FLOW_CALL) || (FLOW == FLOW_INTERRUPT);
    assign is_pop   = (FLOW == FLOW_RETURN);
    assign ptr_zero = (file_select_pointer == `IND_PORT_ADDR);

    // Counter next value selection
    always_comb
    begin
        unique case (FLOW)
            FLOW_NEXT:      next_pc = pc + 13'h0001;
            FLOW_HOLD:      next_pc = pc;
            FLOW_LOW_WRITE: next_pc = {pc_high_latch, LOW_DATA};
            FLOW_BRANCH,
            FLOW_CALL:      next_pc = {pc_high_latch[`LATCH_LOAD_HI:`LATCH_PAGE_BIT], TARGET};
            FLOW_INTERRUPT: next_pc = 13'(VECTOR);
            FLOW_RETURN:    next_pc = stack[top];
            default:        next_pc = pc + 13'h0001;
        endcase
    end

    // Counter register
    always_ff @(posedge CLK)
    begin
        if (RST)
            pc <= `PC_RESET;
        else
            pc <= next_pc;
    end

    // High latch, written only by the core, never by the stack
    always_ff @(posedge CLK)
    begin
        if (RST)
            pc_high_latch <= `LATCH_RESET;
        else if (LATCH_WE)
            pc_high_latch <= LATCH_DATA;
    end

    // Stack pointer, wraps with no overflow indication
    always_ff @(posedge CLK)
    begin
        if (RST)
            sp <= '0;
        else if (is_push)
            sp <= sp + SPW'(1);
        else if (is_pop)
            sp <= top;
    end

    // Stack storage holds the return address
    always_ff @(posedge CLK)
    begin
        if (is_push && FLOW == FLOW_CALL)
            stack[sp] <= pc + 13'h0001;
        else if (is_push)
            stack[sp] <= pc;
    end

    // Indirect pointer register
    always_ff @(posedge CLK)
    begin
        if (RST)
            file_select_pointer <= `PTR_RESET;
        else if (PTR_WE)
            file_select_pointer <= PTR_DATA;
    end

    // Indirect access routing
    assign FILE_ADDR  = {BANK_BIT, file_select_pointer};
    assign FILE_RE    = IND_RE && !ptr_zero;
    assign FILE_WE    = IND_WE && !ptr_zero;
    assign FILE_WDATA = IND_WDATA;
    assign IND_RDATA  = ptr_zero ? 8'h00 : FILE_RDATA;

    // Visible state
    assign PC      = pc;
    assign PC_LOW  = pc[7:0];
    assign LATCH   = pc_high_latch;
    assign POINTER = file_select_pointer;

    // Checks on the counter, the stack and the indirect routing
    // Each one watches state or outputs that this block drives
    // Reset checks run unconditionally, the others pause in reset

    // Reset clears the counter
    // Any reset, whatever the command in flight
    a_reset_clears: assert property (@(posedge CLK) RST |=> pc == 13'h0000)
        else $error("counter not cleared by reset");

    // Reset clears the high latch
    // So the first low write after reset lands in page zero
    a_reset_latch: assert property (@(posedge CLK) RST |=> pc_high_latch == `LATCH_RESET)
        else $error("latch not cleared by reset");

    // Reset clears the indirect pointer
    // The pointer then aims at the port itself
    a_reset_pointer: assert property (@(posedge CLK) RST |=> file_select_pointer == `PTR_RESET)
        else $error("pointer not cleared by reset");

    // Reset returns the hidden stack pointer to slot zero
    // Stack contents are left as they were
    a_reset_sp: assert property (@(posedge CLK) RST |=> sp == '0)
        else $error("stack pointer not cleared by reset");

    // Low byte write takes all five latch bits
    // Latch written in the same cycle is not seen yet
    a_low_write_load: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_LOW_WRITE |=> pc == {$past(pc_high_latch), $past(LOW_DATA)})
        else $error("low write did not load counter");

    // Call target is opcode bits under the page bits
    // The page comes from the latch, never from the old counter
    a_call_page: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_CALL |=> pc[10:0] == $past(TARGET) && pc[12:11] == $past(pc_high_latch[4:3]))
        else $error("call target wrong");

    // Goto target is formed the same way as a call
    // Only the stack treatment differs
    a_goto_page: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_BRANCH |=> pc[10:0] == $past(TARGET) && pc[12:11] == $past(pc_high_latch[4:3]))
        else $error("goto target wrong");

    // Goto leaves the stack alone
    // A push here would corrupt later returns
    a_goto_no_push: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_BRANCH |=> $stable(sp))
        else $error("goto moved the stack");

    // Call stores the address after the call
    // The stored entry sits just under the new pointer
    a_call_push: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_CALL |=> sp == $past(sp) + SPW'(1) && stack[top] == $past(pc) + 13'h0001)
        else $error("call did not push return address");

    // Interrupt jumps to the fixed vector
    // Vector is a parameter of the block
    a_int_vector: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_INTERRUPT |=> pc == 13'(VECTOR))
        else $error("interrupt did not reach the vector");

    // Interrupt stores the interrupted address itself
    // The core presents the address that was not executed
    a_int_push: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_INTERRUPT |=> stack[top] == $past(pc))
        else $error("interrupt did not push the counter");

    // Any return steps the pointer back by one
    // Literal and interrupt returns share this command
    a_return_pop: assert property (@(posedge CLK) disable iff (RST)
        is_pop |=> sp == $past(top))
        else $error("return did not pop the stack");

    // Call then return lands after the call
    // Back to back commands with no idle cycle
    a_call_return: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_CALL ##1 FLOW == FLOW_RETURN |=> pc == $past(pc, 2) + 13'h0001)
        else $error("return address wrong");

    // Stack traffic leaves the latch alone
    // Returns never need the page bits fixed up
    a_latch_kept: assert property (@(posedge CLK) disable iff (RST)
        (is_push || is_pop) && !LATCH_WE |=> $stable(pc_high_latch))
        else $error("latch changed by stack");

    // Latch write takes the new value
    // Only the core writes the latch
    a_latch_write: assert property (@(posedge CLK) disable iff (RST)
        LATCH_WE |=> pc_high_latch == $past(LATCH_DATA))
        else $error("latch write lost");

    // Latch holds when not written
    // Covers every flow command, stack ones included
    a_latch_hold: assert property (@(posedge CLK) disable iff (RST)
        !LATCH_WE |=> $stable(pc_high_latch))
        else $error("latch changed without a write");

    // Ninth push wraps onto the first slot
    // No overflow flag is raised
    a_stack_wrap: assert property (@(posedge CLK) disable iff (RST)
        is_push && sp == SPW'(DEPTH - 1) |=> sp == '0)
        else $error("stack did not wrap");

    // Pop from slot zero wraps to the last slot
    // No underflow flag is raised either
    a_pop_wrap: assert property (@(posedge CLK) disable iff (RST)
        is_pop && sp == '0 |=> sp == SPW'(DEPTH - 1))
        else $error("pop did not wrap");

    // Stack pointer rests without push or pop
    // Software has no path to it
    a_sp_idle: assert property (@(posedge CLK) disable iff (RST)
        !is_push && !is_pop |=> $stable(sp))
        else $error("stack pointer moved on its own");

    // Pointer write takes the new value
    // The next indirect access aims at it
    a_pointer_write: assert property (@(posedge CLK) disable iff (RST)
        PTR_WE |=> file_select_pointer == $past(PTR_DATA))
        else $error("pointer write lost");

    // Pointer holds when not written
    // Indirect accesses never move it
    a_pointer_hold: assert property (@(posedge CLK) disable iff (RST)
        !PTR_WE |=> $stable(file_select_pointer))
        else $error("pointer changed without a write");

    // Indirect read reaches the selected register
    // Data comes straight back from the file
    a_read_route: assert property (@(posedge CLK) disable iff (RST)
        IND_RE && !ptr_zero |-> FILE_RE && IND_RDATA == FILE_RDATA)
        else $error("indirect read not routed");

    // Indirect write reaches the selected register
    // Write data passes unchanged
    a_write_route: assert property (@(posedge CLK) disable iff (RST)
        IND_WE && !ptr_zero |-> FILE_WE && FILE_WDATA == IND_WDATA)
        else $error("indirect write not routed");

    // No file read without a core read
    // A stray strobe could upset read-sensitive registers
    a_no_stray_read: assert property (@(posedge CLK) disable iff (RST)
        !IND_RE |-> !FILE_RE)
        else $error("file read without request");

    // No file write without a core write
    // A stray strobe would corrupt a register
    a_no_stray_write: assert property (@(posedge CLK) disable iff (RST)
        !IND_WE |-> !FILE_WE)
        else $error("file write without request");

    // Zero pointer read returns zero
    // The file is not even strobed
    a_zero_read: assert property (@(posedge CLK) disable iff (RST)
        IND_RE && ptr_zero |-> IND_RDATA == 8'h00 && !FILE_RE)
        else $error("zero pointer read not zero");

    // Zero pointer write goes nowhere
    // Status side effects are the core's business
    a_self_write: assert property (@(posedge CLK) disable iff (RST)
        IND_WE && ptr_zero |-> !FILE_WE)
        else $error("write to port reached a register");

    // Plain advance adds one
    // The usual case between branches
    a_step_one: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_NEXT |=> pc == $past(pc) + 13'h0001)
        else $error("counter did not advance");

    // Advance from the top wraps to zero
    // No carry leaks beyond thirteen bits
    a_pc_wrap: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_NEXT && pc == 13'h1FFF |=> pc == 13'h0000)
        else $error("counter did not wrap");

    // Hold keeps the counter
    // Used by the core for stalls
    a_hold_keeps: assert property (@(posedge CLK) disable iff (RST)
        FLOW == FLOW_HOLD |=> $stable(pc))
        else $error("counter moved during hold");
endmodule : pcstk
`default_nettype wire

// file: dv/regfile_model.sv
// Purpose: register file behind the indirect data port
// Assumes: combinational read, write on the clock edge
// Notes:   cells start at A5 so a gated read is visible
`default_nettype none
module regfile_model
(
    input  wire logic       clk,
    input  wire logic [8:0] addr,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [512] = '{default: 8'hA5}; // Cell array
    // Store on write strobe
    always_ff @(posedge clk)
    begin
        if (we) mem[addr] <= wdata;
    end
    assign rdata = mem[addr]; // Read follows address
endmodule : regfile_model
`default_nettype wire

// file: dv/pcstk_tb.sv
// Purpose: self-checking bench for the program flow block
// Assumes: inputs change at rising edges, checks at falling
// Notes:   each step holds its command for one edge
`default_nettype none
module pcstk_tb
    import pcstk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RST = 1, LATCH_WE = 0, PTR_WE = 0, BANK_BIT = 0, IND_RE = 0, IND_WE = 0, FILE_RE, FILE_WE;
    flow_t FLOW = FLOW_HOLD;
    logic [10:0] TARGET = '0;
    logic [7:0] LOW_DATA = '0, PTR_DATA = '0, IND_WDATA = '0, FILE_RDATA, PC_LOW, POINTER, FILE_WDATA, IND_RDATA;
    logic [4:0] LATCH_DATA = '0, LATCH;
    logic [12:0] PC;
    logic [8:0] FILE_ADDR;
    int fails = 0, n_compared = 0;
    always #4 CLK = ~CLK; // 125 MHz core clock
    pcstk u_dut (.CLK(CLK), .RST(RST), .FLOW(FLOW), .TARGET(TARGET), .LOW_DATA(LOW_DATA),
        .LATCH_WE(LATCH_WE), .LATCH_DATA(LATCH_DATA), .PTR_WE(PTR_WE), .PTR_DATA(PTR_DATA),
        .BANK_BIT(BANK_BIT), .IND_RE(IND_RE), .IND_WE(IND_WE), .IND_WDATA(IND_WDATA),
        .FILE_RDATA(FILE_RDATA), .PC(PC), .PC_LOW(PC_LOW), .LATCH(LATCH), .POINTER(POINTER),
        .FILE_ADDR(FILE_ADDR), .FILE_RE(FILE_RE), .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA),
        .IND_RDATA(IND_RDATA));
    regfile_model u_rf (.clk(CLK), .addr(FILE_ADDR), .we(FILE_WE), .wdata(FILE_WDATA), .rdata(FILE_RDATA));
    // Compare and count
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // One command, then hold; the indirect strobes stay up until the next step
    task automatic step(input flow_t f, input logic [10:0] t, input logic lwe, pwe, iwe, ire, input logic [7:0] d);
        @(posedge CLK);
        {FLOW, TARGET, LOW_DATA, LATCH_DATA, PTR_DATA, IND_WDATA} <= {f, t, d, d[4:0], d, d};
        {LATCH_WE, PTR_WE, IND_WE, IND_RE} <= {lwe, pwe, iwe, ire};
        @(posedge CLK);
        {FLOW, LATCH_WE, PTR_WE} <= {FLOW_HOLD, 2'b00};
        @(negedge CLK);
    endtask : step
    // Low byte write takes all upper bits, then wraps on advance
    task automatic t_low;
        step(FLOW_HOLD, 0, 1, 0, 0, 0, 8'h1F);
        step(FLOW_LOW_WRITE, 0, 0, 0, 0, 0, 8'hFF);
        chk(PC, 13'h1FFF);
        chk(PC_LOW, 8'hFF);
        step(FLOW_NEXT, 0, 0, 0, 0, 0, 8'h00);
        chk(PC, 13'h0000);
    endtask : t_low
    // Paged call, return, interrupt branch
    task automatic t_call;
        step(FLOW_HOLD, 0, 1, 0, 0, 0, 8'h0A);
        step(FLOW_LOW_WRITE, 0, 0, 0, 0, 0, 8'h34);
        step(FLOW_CALL, 11'h7C5, 0, 0, 0, 0, 8'h00);
        chk(PC, 13'h0FC5);
        step(FLOW_RETURN, 0, 0, 0, 0, 0, 8'h00);
        chk(PC, 13'h0A35);
        chk(LATCH, 5'h0A);
        step(FLOW_INTERRUPT, 0, 0, 0, 0, 0, 8'h00);
        chk(PC, 13'h0004);
        step(FLOW_RETURN, 0, 0, 0, 0, 0, 8'h00);
        chk(PC, 13'h0A35);
    endtask : t_call
    // Nine calls: the ninth push lands on the first slot
    task automatic t_wrap;
        for (int i = 0; i < 9; i++) step(FLOW_CALL, 11'(i), 0, 0, 0, 0, 8'h00);
        for (int j = 0; j < 9; j++)
        begin
            step(FLOW_RETURN, 0, 0, 0, 0, 0, 8'h00);
            chk(PC, (j < 8) ? 13'(13'h808 - j) : 13'h808);
        end
    endtask : t_wrap
    // Indirect port through pointer, and the zero-pointer case
    task automatic t_ind;
        BANK_BIT <= 1'b1;
        step(FLOW_HOLD, 0, 0, 1, 0, 0, 8'h05);
        chk(POINTER, 8'h05);
        step(FLOW_HOLD, 0, 0, 0, 1, 0, 8'h3C);
        chk(FILE_WE, 1'b1);
        chk(FILE_WDATA, 8'h3C);
        chk(FILE_ADDR, 9'h105);
        step(FLOW_HOLD, 0, 0, 0, 0, 1, 8'h00);
        chk(FILE_RE, 1'b1);
        chk(IND_RDATA, 8'h3C);
        step(FLOW_HOLD, 0, 0, 1, 0, 0, 8'h00);
        step(FLOW_HOLD, 0, 0, 0, 1, 0, 8'h77);
        chk(FILE_WE, 1'b0);
        step(FLOW_HOLD, 0, 0, 0, 0, 1, 8'h00);
        chk(FILE_RE, 1'b0);
        chk(IND_RDATA, 8'h00);
    endtask : t_ind
    // Goto, then call and return back to back
    task automatic t_b2b;
        @(posedge CLK);
        {FLOW, TARGET} <= {FLOW_BRANCH, 11'h123};
        @(posedge CLK);
        {FLOW, TARGET} <= {FLOW_CALL, 11'h456};
        @(negedge CLK);
        chk(PC, 13'h0923);
        @(posedge CLK);
        FLOW <= FLOW_RETURN;
        @(negedge CLK);
        chk(PC, 13'h0C56);
        @(posedge CLK);
        FLOW <= FLOW_HOLD;
        @(negedge CLK);
        chk(PC, 13'h0924);
    endtask : t_b2b
    // Reset in mid-run clears the counter
    task automatic t_rst;
        step(FLOW_LOW_WRITE, 0, 0, 0, 0, 0, 8'h99);
        chk(PC, 13'h0A99);
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        chk(PC, 13'h0000);
    endtask : t_rst
    // Verdict and end of run
    task automatic close_out;
        $display("compared %0d, fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Main sequence
    initial
    begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(negedge CLK);
        chk(PC, 13'h0000);
        t_low();
        t_call();
        t_wrap();
        t_b2b();
        t_ind();
        t_rst();
        close_out();
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge CLK);
        fails++;
        close_out();
    end
endmodule : pcstk_tb
`default_nettype wire
